// [shared/spi_hold_pkg.sv]
// Purpose: Shared constants and types for the serial master with select hold.
// Assumes: 32-bit classic Wishbone register port, 25 MHz system clock.
// Notes: Register offsets are byte addresses of aligned words.
package spi_hold_pkg;
   // Register map.
   localparam logic [3:0] TX_CTRL_OFS = 4'h0;
   localparam logic [3:0] MODE_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   // Field positions in the transmit-data/control and mode registers.
   localparam int HOLD_BIT = 28;
   localparam int DATA_W = 16;
   localparam int MODE_MASTER_BIT = 0;
   // Status register field positions.
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_SELECT_BIT = 1;
   localparam int ST_FULL_BIT = 2;
   localparam int ST_EMPTY_BIT = 3;
   localparam int ST_RX_LSB = 16;
   // Values after reset.
   localparam logic HOLD_RESET = 1'b0;
   localparam logic MASTER_RESET = 1'b0;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   // Timing: serial clock half period; FIFO depth.
   localparam int SYS_CLK_NS = 40;
   localparam int SCLK_HALF_NS = 160;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic hold;
      logic [DATA_W-1:0] data;
   } tx_word_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_SHIFT = 2'b10,
      ST_TRAIL = 2'b11
   } spi_state_t;

   // True when a bus address selects the register at the given offset.
   function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] ofs);
      return adr[3:2] == ofs[3:2];
   endfunction : reg_hit
endpackage : spi_hold_pkg

// [core/spi_master_cs_hold.sv]
// Purpose: Serial master whose select line can be held across words.
// Assumes: Wishbone master keeps the request until ack; slave is mode 0.
// Notes: A 16-word FIFO sits between the register port and the shifter.
//    A data write stalls its ack while the FIFO is full, so no queued word is ever lost.
//    miso passes two flip-flops before the shifter reads it, so HALF_CYC below 3 samples
//    a stale bit; the trade buys a clean pin crossing at the cost of a slower link.
`timescale 1ns/1ns
`default_nettype none

module spi_word_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   always_comb begin
      in_ready = count != (AW+1)'(DEPTH);
      out_valid = count != '0;
      out_data = mem[rd_ptr];
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // The storage has no reset; only words counted as held are ever read.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : spi_word_fifo

module spi_master_cs_hold
   import spi_hold_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Classic Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Serial link.
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   output logic peripheral_select_out_n
);
   // Bus side state.
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic select_hold_flag, next_select_hold_flag;
   logic master_en, next_master_en;
   logic [DATA_W-1:0] last_data, next_last_data;
   logic req, wr_tx, data_wr, hold_wr, push_ok, hold_go;
   logic hold_only;
   tx_word_t push_word;
   // FIFO.
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   tx_word_t fifo_out;
   // Serial side state.
   spi_state_t state, next_state;
   logic [7:0] cnt, next_cnt;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [DATA_W-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
   logic [DATA_W-1:0] rx_data, next_rx_data;
   logic sclk_q, next_sclk;
   logic cs_active, next_cs_active;
   logic word_hold, next_word_hold;
   logic miso_meta, miso_s;
   logic half_done;

   always_comb begin
      req = cyc_i & stb_i & ~ack;
      wr_tx = req & we_i & reg_hit(adr_i, TX_CTRL_OFS);
      // Only a write covering both low data bytes queues a word.
      data_wr = wr_tx & sel_i[1] & sel_i[0];
      hold_wr = wr_tx & sel_i[3];
      // A full FIFO stalls the bus answer, so no word is ever dropped.
      push_ok = ~data_wr | fifo_in_ready;
      next_ack = req & push_ok;
      hold_go = hold_wr & push_ok;
      // Only a write that leaves the data bytes alone may move an idle select line.
      // A full write must not, or a held line would blink off before its next word.
      hold_only = hold_go & ~data_wr;
      push_word.data = dat_i[DATA_W-1:0];
      // A full-width write carries its own hold; a halfword uses the stored one.
      push_word.hold = sel_i[3] ? dat_i[HOLD_BIT] : select_hold_flag;
      next_select_hold_flag = hold_go ? dat_i[HOLD_BIT] : select_hold_flag;
      next_last_data = (data_wr & push_ok) ? dat_i[DATA_W-1:0] : last_data;
      next_master_en = master_en;
      if (req & we_i & reg_hit(adr_i, MODE_OFS) & sel_i[0]) begin
         next_master_en = dat_i[MODE_MASTER_BIT];
      end
      next_rdata = rdata;
      if (req & ~we_i) begin
         next_rdata = '0;
         if (reg_hit(adr_i, TX_CTRL_OFS)) begin
            next_rdata[HOLD_BIT] = select_hold_flag;
            next_rdata[DATA_W-1:0] = last_data;
         end else if (reg_hit(adr_i, MODE_OFS)) begin
            next_rdata[MODE_MASTER_BIT] = master_en;
         end else if (reg_hit(adr_i, STATUS_OFS)) begin
            next_rdata[ST_BUSY_BIT] = (state != ST_IDLE) | fifo_out_valid;
            next_rdata[ST_SELECT_BIT] = cs_active;
            next_rdata[ST_FULL_BIT] = ~fifo_in_ready;
            next_rdata[ST_EMPTY_BIT] = ~fifo_out_valid;
            next_rdata[ST_RX_LSB +: DATA_W] = rx_data;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack <= 1'b0;
         rdata <= '0;
         select_hold_flag <= HOLD_RESET;
         master_en <= MASTER_RESET;
         last_data <= DATA_RESET;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
         select_hold_flag <= next_select_hold_flag;
         master_en <= next_master_en;
         last_data <= next_last_data;
      end
   end

   assign ack_o = ack;
   assign dat_o = rdata;

   spi_word_fifo #(
      .WIDTH($bits(tx_word_t)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(data_wr),
      .in_ready(fifo_in_ready),
      .in_data(push_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   always_comb begin
      half_done = cnt == 8'(HALF_CYC - 1);
      next_state = state;
      next_cnt = half_done ? 8'h00 : cnt + 8'h01;
      next_bit_cnt = bit_cnt;
      next_tx_sh = tx_sh;
      next_rx_sh = rx_sh;
      next_rx_data = rx_data;
      next_sclk = sclk_q;
      next_cs_active = cs_active;
      next_word_hold = word_hold;
      fifo_out_ready = 1'b0;
      case (state)
         ST_IDLE: begin
            next_cnt = 8'h00;
            if (!master_en) begin
               next_cs_active = 1'b0;
            end else if (fifo_out_valid) begin
               fifo_out_ready = 1'b1;
               next_tx_sh = fifo_out.data;
               next_word_hold = fifo_out.hold;
               // Select goes active a full half period before the first edge.
               next_cs_active = 1'b1;
               next_bit_cnt = 4'h0;
               next_state = ST_LEAD;
            end else if (hold_only) begin
               next_cs_active = dat_i[HOLD_BIT];
            end
         end
         ST_LEAD: begin
            if (half_done) begin
               next_sclk = 1'b1;
               next_rx_sh = {rx_sh[DATA_W-2:0], miso_s};
               next_state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (half_done) begin
               next_sclk = ~sclk_q;
               if (!sclk_q) begin
                  next_rx_sh = {rx_sh[DATA_W-2:0], miso_s};
               end else if (bit_cnt == 4'hF) begin
                  next_state = ST_TRAIL;
               end else begin
                  next_tx_sh = {tx_sh[DATA_W-2:0], 1'b0};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
         end
         ST_TRAIL: begin
            if (half_done) begin
               // The hold captured with this word decides the select after it.
               next_cs_active = word_hold;
               next_rx_data = rx_sh;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cs_active = 1'b0;
            next_sclk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cnt <= 8'h00;
         bit_cnt <= 4'h0;
         tx_sh <= DATA_RESET;
         rx_sh <= DATA_RESET;
         rx_data <= DATA_RESET;
         sclk_q <= 1'b0;
         cs_active <= 1'b0;
         word_hold <= HOLD_RESET;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         bit_cnt <= next_bit_cnt;
         tx_sh <= next_tx_sh;
         rx_sh <= next_rx_sh;
         rx_data <= next_rx_data;
         sclk_q <= next_sclk;
         cs_active <= next_cs_active;
         word_hold <= next_word_hold;
      end
   end

   // Two flip-flops take miso across from the pin; only the second one is read.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         miso_meta <= 1'b0;
         miso_s <= 1'b0;
      end else begin
         miso_meta <= miso;
         miso_s <= miso_meta;
      end
   end

   assign sclk = sclk_q;
   assign mosi = tx_sh[DATA_W-1];
   assign peripheral_select_out_n = ~cs_active;
endmodule : spi_master_cs_hold

`default_nettype wire

// [tb/spi_hold_monitor.sv]
// Purpose: Port-level checks for the serial master with select hold.
// Assumes: Hold-only writes are issued only once the shifter is idle.
// Notes: Master mode is tracked from MODE writes because no pin shows it.
`timescale 1ns/1ns
`default_nettype none
module spi_hold_monitor
   import spi_hold_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Register bus.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   // Serial link.
   input wire logic sclk,
   input wire logic peripheral_select_out_n
);
   localparam int QUIET = 2 * HALF_CYC;
   logic master;
   int quiet;
   logic tx_wr;
   logic hold_wr;
   logic data_wr;
   assign tx_wr = ack_o && we_i && adr_i[3:2] == 2'h0 && master;
   assign hold_wr = tx_wr && sel_i == 4'h8 && quiet >= QUIET;
   assign data_wr = tx_wr && sel_i == 4'hF && quiet >= QUIET;
   // A low sclk lasting two half periods (QUIET cycles) means no word is being shifted.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         master <= 1'b0;
         quiet <= 0;
      end else begin
         if (ack_o && we_i && adr_i[3:2] == 2'h1 && sel_i[0])
            master <= dat_i[0];
         quiet <= sclk ? 0 : (quiet < QUIET ? quiet + 1 : QUIET);
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence quiet_gap;
      (!sclk)[*6];
   endsequence
   a_select_before_clk: assert property ($rose(sclk) |->
      !peripheral_select_out_n && !$past(peripheral_select_out_n)) else $error("select late");
   a_select_past_fall: assert property ($fell(sclk) |=>
      !peripheral_select_out_n) else $error("select dropped at bit end");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_ack_has_req: assert property (ack_o |-> cyc_i && stb_i) else $error("stray ack");
   a_master_only: assert property (!master && !$past(master) |->
      peripheral_select_out_n && !sclk) else $error("link active in slave mode");
   a_hold_drives_sel: assert property (hold_wr |->
      peripheral_select_out_n == !dat_i[HOLD_BIT]) else $error("hold write ignored");
   a_hold_no_xfer: assert property (hold_wr |=> quiet_gap) else $error("hold write shifted");
   a_full_write_sel: assert property (data_wr |->
      ##[1:12] !peripheral_select_out_n) else $error("word never selected");
   a_no_select_gap: assert property (data_wr && !$past(peripheral_select_out_n) |->
      (!peripheral_select_out_n)[*8]) else $error("select gap before next word");
endmodule : spi_hold_monitor
bind spi_master_cs_hold spi_hold_monitor #(.HALF_CYC(HALF_CYC)) mon_u (.sys_clk(sys_clk),
   .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .ack_o(ack_o), .sclk(sclk), .peripheral_select_out_n(peripheral_select_out_n));
`default_nettype wire

// [tb/spi_slave_model.sv]
// Purpose: Behavioural serial slave that records words and answers a fixed reply.
// Assumes: Mode 0 link, MSB first, select active low.
// Notes: A deselected miso toggles so that stale data never looks valid.
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model #(
   parameter logic [15:0] REPLY = 16'hA5C3
) (
   // Link.
   input wire logic sys_clk,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cs_n,
   output logic miso,
   // Observation.
   output logic [15:0] rx_word,
   output int rx_count
);
   int bits = 0;
   initial begin
      miso = 1'b0;
      rx_word = 16'h0000;
      rx_count = 0;
   end
   always @(posedge sclk) begin
      rx_word = {rx_word[14:0], mosi};
      bits = bits + 1;
      if (bits == 16) begin
         rx_count = rx_count + 1;
         bits = 0;
      end
   end
   always @(negedge sys_clk) begin
      if (cs_n) begin
         miso <= ~miso;
         bits = 0;
      end else if (!sclk) begin
         miso <= REPLY[15 - bits];
      end
   end
endmodule : spi_slave_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the serial master with select hold.
// Assumes: HALF_CYC 4 gives the 320 ns link clock; DEPTH 4 keeps the run short.
// Notes: Every register access goes through one classic Wishbone task.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import spi_hold_pkg::*;
;
   typedef struct {logic [3:0] sel; logic [31:0] dat; logic [15:0] word; int n; logic cs;} row_t;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] adr_i = 4'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, q;
   logic ack_o, sclk, mosi, miso, cs_n;
   logic [15:0] rx_word;
   int rx_count, base, rbase;
   int errors = 0;
   int checked = 0;
   int rises = 0;
   row_t rows[6] = '{'{4'hF, 32'h00005678, 16'h5678, 1, 1'b1},
      '{4'hF, 32'h10001234, 16'h1234, 1, 1'b0},
      '{4'h8, 32'h00000000, 16'h1234, 0, 1'b1},
      '{4'h8, 32'h10000000, 16'h1234, 0, 1'b0},
      '{4'h3, 32'h0000BEEF, 16'hBEEF, 1, 1'b0},
      '{4'h8, 32'h00000000, 16'hBEEF, 0, 1'b1}};
   spi_master_cs_hold #(.HALF_CYC(4), .DEPTH(4)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .sclk(sclk), .mosi(mosi), .miso(miso),
      .peripheral_select_out_n(cs_n));
   spi_slave_model slave_u (.sys_clk(sys_clk), .sclk(sclk), .mosi(mosi), .cs_n(cs_n),
      .miso(miso), .rx_word(rx_word), .rx_count(rx_count));
   always #20 sys_clk = ~sys_clk;
   always @(posedge cs_n) rises++;
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic wb(input logic [3:0] a, input logic [3:0] s, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, d};
      do @(posedge sys_clk); while (ack_o !== 1'b1);
      q = dat_o;
      {cyc_i, stb_i} <= 2'h0;
   endtask : wb
   task automatic wait_idle();
      do wb(STATUS_OFS, 4'hF, 1'b0, 32'h0);
      while (q[ST_BUSY_BIT] !== 1'b0 || q[ST_EMPTY_BIT] !== 1'b1);
   endtask : wait_idle
   task automatic finish_test();
      $display("Counts: %0d checked, %0d errors", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // About 1500 cycles are expected; the 25000-cycle limit still ends a hang quickly.
   initial begin
      #1000000;
      errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      wb(TX_CTRL_OFS, 4'hF, 1'b0, 32'h0);
      check(q, 32'h0);
      // Slave mode: the word and a hold-only write must leave the link idle.
      wb(TX_CTRL_OFS, 4'hF, 1'b1, 32'h10001234);
      wb(TX_CTRL_OFS, 4'h8, 1'b1, 32'h10000000);
      repeat (40) @(posedge sys_clk);
      check(32'(rx_count), 32'h0);
      check(32'(cs_n), 32'h1);
      wb(MODE_OFS, 4'hF, 1'b1, 32'h1);
      wait_idle();
      check(32'(rx_word), 32'h1234);
      check(32'(cs_n), 32'h0);
      check(32'(q[31:16]), 32'hA5C3);
      $display("Mode test done");
      for (int i = 0; i < 6; i++) begin
         base = rx_count;
         rbase = rises;
         wb(TX_CTRL_OFS, rows[i].sel, 1'b1, rows[i].dat);
         wait_idle();
         check(32'(rx_count - base), 32'(rows[i].n));
         check(32'(rx_word), 32'(rows[i].word));
         check(32'(cs_n), 32'(rows[i].cs));
         check(32'(rises - rbase), 32'(rows[i].cs));
         $display("Row %0d done", i);
      end
      base = rises;
      wb(TX_CTRL_OFS, 4'hF, 1'b1, 32'h10001234);
      wb(TX_CTRL_OFS, 4'hF, 1'b1, 32'h00005678);
      wait_idle();
      check(32'(rises - base), 32'h1);
      check(32'(rx_word), 32'h5678);
      $display("Back to back test done");
      wb(MODE_OFS, 4'hF, 1'b1, 32'h0);
      base = rx_count;
      for (int i = 0; i < 4; i++)
         wb(TX_CTRL_OFS, 4'hF, 1'b1, 32'h00000A00 + 32'(i));
      wb(STATUS_OFS, 4'hF, 1'b0, 32'h0);
      check(32'(q[ST_FULL_BIT]), 32'h1);
      wb(MODE_OFS, 4'hF, 1'b1, 32'h1);
      wait_idle();
      check(32'(rx_count - base), 32'h4);
      check(32'(rx_word), 32'h0A03);
      wb(4'hC, 4'hF, 1'b0, 32'h0);
      check(q, 32'h0);
      $display("Buffer test done");
      // A reset in mid-word must release the link at once and clear the registers.
      wb(TX_CTRL_OFS, 4'hF, 1'b1, 32'h10001234);
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(32'({cs_n, sclk, mosi, ack_o}), 32'h8);
      check(dat_o, 32'h0);
      nrst <= 1'b1;
      wb(TX_CTRL_OFS, 4'hF, 1'b0, 32'h0);
      check(q, 32'h0);
      wb(MODE_OFS, 4'hF, 1'b0, 32'h0);
      check(q, 32'h0);
      $display("Reset test done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
